// ### src/audio_pwm_sample_buffer.sv
// Purpose: Sample feeding front end of an audio PWM driver, Wishbone slave
// Assumes: sys_clk_i is the PWM clock; period length is a parameter
// Notes:   Modulator and drivers are outside; sample_o feeds them
// Summary of operation
// - Hardware alone writes status: 00 empty, 01 buffer only, 10 both.
// - Empty or just-read buffer is loaded from the play sample pair.
// - Low byte moves into buffer first, high byte second.
// - One clock before period end buffer is read, reload flag set.
// - Empty flag set at read unless a new sample had been written.
// - Insertion code 00,01,10,11 gives 0,1,3,7 points.
// - N-bit resolution keeps bits 15..16-N-1 green, 15..16-N normal; green at N=16 masks all bits to 0.
// - While mute control is 0 the pair reads 8000H, writes ignored.
// - Sample 0001H plays exactly as 0000H.
// - Low and high sample registers fully read/write, bits 7..0, 15..8.
// - Normal op select 0 symmetric around 8000H, 1 asymmetric.
// - On enable rising, first sample 8000H, then current pair value.
// - Interpolated points step by difference over count plus one.
//
// Chosen here: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "audio_pwm_params.svh"
module audio_pwm_sample_buffer #(
  parameter int PERIOD_CLKS  = `PERIOD_LEN,
  parameter int MULTI_PERIOD = `PERIOD_MULTI
) (
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [15:0] sample_o,
  output logic             period_end_o,
  output logic             normal_op_select_o,
  output logic             pwm_enable_o,
  output logic             green_mode_o,
  output logic             reload_done_flag_o,
  output logic             buffer_empty_flag_o
);
  initial begin
    if (PERIOD_CLKS < 2 || PERIOD_CLKS > 65535) $error("PERIOD_CLKS out of range");
    if (MULTI_PERIOD < 2 || MULTI_PERIOD > 255) $error("MULTI_PERIOD out of range");
  end

  function automatic logic [2:0] insert_count(input logic [1:0] code);
    case (code)
      2'b00:   insert_count = 3'd0;
      2'b01:   insert_count = 3'd1;
      2'b10:   insert_count = 3'd3;
      default: insert_count = 3'd7;
    endcase
  endfunction

  // Keeps the top N bits of a sample, N+1 in green mode for N below 16 and none for green N=16; 0001 plays as 0000
  function automatic logic [15:0] effective(input logic [15:0] s, input logic [1:0] rsel,
                                            input logic green);
    logic [4:0]  n;
    logic [4:0]  x;
    logic [15:0] m;
    n = 5'd10 + {2'b00, rsel, 1'b0};
    x = green ? 5'd16 - n - 5'd1 : 5'd16 - n;
    m = 16'hFFFF << x;
    effective = (s == 16'h0001 ? 16'h0000 : s) & m;
  endfunction

  logic       wr;
  logic       acc;
  logic       clear_q;
  logic       clear_prev_q;
  logic       normal_q;
  logic       period_q;
  logic [1:0] insert_q;
  logic [7:0] low_q;
  logic [7:0] high_q;
  logic       enable_q;
  logic       enable_prev_q;
  logic       mute_q;
  logic       green_q;
  logic [1:0] rsel_q;
  logic       pend_q;
  logic       buf_full_q;
  logic [15:0] buf_q;
  logic       new_sample_q;
  logic [15:0] cnt_q;
  logic [7:0] rep_q;
  logic [2:0] step_q;
  logic       first_q;
  logic [15:0] prev_q;
  logic [15:0] cur_q;
  logic       ack_q;
  logic       reload_q;
  logic       empty_q;
  logic [15:0] interp;
  logic       read_pt;
  logic       clear_edge;
  logic [7:0] reps;
  logic       last_rep;
  logic       last_step;
  audio_pwm_pkg::load_state_t load_q;

  assign acc = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr  = acc && wb_we_i && wb_sel_i[0];
  assign clear_edge = clear_q && !clear_prev_q;
  assign reps = period_q ? 8'(MULTI_PERIOD) : 8'h01;
  // At or past the last count, so lowering a count mid-group cannot skip the wrap
  assign last_rep  = rep_q >= reps - 8'h01;
  assign last_step = step_q >= insert_count(insert_q);
  assign read_pt   = enable_q && cnt_q == 16'(PERIOD_CLKS - 2) && last_rep
                     && last_step;

  // Ack one cycle after a request is taken; ack_q blocks a second take
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc;
    end
  end
  assign wb_ack_o = ack_q;

  // Control and mode registers
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      clear_q      <= 1'b0;
      clear_prev_q <= 1'b0;
      normal_q     <= 1'b0;
      period_q     <= 1'b0;
      insert_q     <= 2'b00;
      enable_q     <= 1'b0;
      mute_q       <= 1'b0;
      green_q      <= 1'b0;
      rsel_q       <= 2'b00;
    end else begin
      clear_prev_q <= clear_q;
      if (wr && wb_adr_i == `ADR_CONTROL) begin
        clear_q  <= wb_dat_i[`CTL_CLEAR_BIT];
        normal_q <= wb_dat_i[`CTL_NORMAL_BIT];
        period_q <= wb_dat_i[`CTL_PERIOD_BIT];
        insert_q <= wb_dat_i[1:0];
      end
      if (wr && wb_adr_i == `ADR_MODE) begin
        enable_q <= wb_dat_i[0];
        mute_q   <= wb_dat_i[1];
        green_q  <= wb_dat_i[2];
        rsel_q   <= wb_dat_i[5:4];
      end
    end
  end

  // Sample pair; a high write marks a complete new sample
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      low_q  <= `LOW_RESET;
      high_q <= `HIGH_RESET;
      pend_q <= 1'b0;
    end else if (!mute_q) begin
      low_q  <= 8'(`SAMPLE_DEFAULT);
      high_q <= 8'(`SAMPLE_DEFAULT >> 8);
      pend_q <= 1'b0;
    end else begin
      if (wr && wb_adr_i == `ADR_SAMPLE_LOW) low_q <= wb_dat_i[7:0];
      if (wr && wb_adr_i == `ADR_SAMPLE_HIGH) high_q <= wb_dat_i[7:0];
      if (wr && wb_adr_i == `ADR_SAMPLE_HIGH) begin
        pend_q <= 1'b1;
      end else if (clear_edge || load_q == audio_pwm_pkg::LOAD_HIGH) begin
        pend_q <= 1'b0;
      end
    end
  end

  // Copy into buffer, low byte then high byte
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || clear_edge) begin
      load_q     <= audio_pwm_pkg::LOAD_IDLE;
      buf_q      <= `SAMPLE_DEFAULT;
      buf_full_q <= 1'b0;
    end else begin
      // A read frees the slot; a load ending in the same cycle still fills it
      if (read_pt) buf_full_q <= 1'b0;
      case (load_q)
        audio_pwm_pkg::LOAD_IDLE: begin
          if (pend_q && (!buf_full_q || read_pt)) load_q <= audio_pwm_pkg::LOAD_LOW;
        end
        audio_pwm_pkg::LOAD_LOW: begin
          buf_q[7:0] <= low_q;
          load_q     <= audio_pwm_pkg::LOAD_HIGH;
        end
        audio_pwm_pkg::LOAD_HIGH: begin
          buf_q[15:8] <= high_q;
          buf_full_q  <= 1'b1;
          load_q      <= audio_pwm_pkg::LOAD_IDLE;
        end
        default: load_q <= audio_pwm_pkg::LOAD_IDLE;
      endcase
    end
  end

  // Period timing, buffer read, reload and empty flags
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      enable_prev_q <= 1'b0;
      cnt_q     <= 16'h0000;
      rep_q     <= 8'h00;
      step_q    <= 3'd0;
      first_q   <= 1'b0;
      prev_q    <= `SAMPLE_DEFAULT;
      cur_q     <= `SAMPLE_DEFAULT;
      reload_q  <= 1'b0;
      empty_q   <= 1'b0;
      new_sample_q <= 1'b0;
    end else begin
      enable_prev_q <= enable_q;
      reload_q <= read_pt;
      empty_q  <= read_pt && !buf_full_q && !pend_q;
      // Enable rise restarts timing and queues the midpoint first
      if (enable_q && !enable_prev_q) begin
        cnt_q   <= 16'h0000;
        rep_q   <= 8'h00;
        step_q  <= 3'd0;
        prev_q  <= `SAMPLE_DEFAULT;
        cur_q   <= `SAMPLE_DEFAULT;
        first_q <= 1'b1;
      end else if (enable_q) begin
        if (cnt_q == 16'(PERIOD_CLKS - 1)) begin
          cnt_q <= 16'h0000;
          if (last_rep) begin
            rep_q <= 8'h00;
            if (last_step) step_q <= 3'd0;
            else step_q <= step_q + 3'd1;
          end else begin
            rep_q <= rep_q + 8'h01;
          end
        end else begin
          cnt_q <= cnt_q + 16'h0001;
        end
        if (read_pt) begin
          prev_q  <= first_q ? `SAMPLE_DEFAULT : cur_q;
          cur_q   <= first_q ? {high_q, low_q} : (buf_full_q ? buf_q : cur_q);
          first_q <= 1'b0;
        end
      end
      new_sample_q <= read_pt;
    end
  end

  // Linear points between prev_q and cur_q, one step per sample group
  sample_interp #(
    .W(16)
  ) u_interp (
    .prev_i  (prev_q),
    .next_i  (cur_q),
    .code_i  (insert_q),
    .step_i  (step_q),
    .point_o (interp)
  );

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sample_o     <= `SAMPLE_DEFAULT;
      period_end_o <= 1'b0;
    end else begin
      period_end_o <= enable_q && cnt_q == 16'(PERIOD_CLKS - 1);
      sample_o     <= effective(new_sample_q ? prev_q : interp, rsel_q, green_q);
    end
  end

  assign normal_op_select_o  = normal_q;
  assign pwm_enable_o        = enable_q;
  assign green_mode_o        = green_q;
  assign reload_done_flag_o  = reload_q;
  assign buffer_empty_flag_o = empty_q;

  // Read data is registered and stands with ack
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      case (wb_adr_i)
        `ADR_CONTROL: wb_dat_o <= {24'h000000, clear_q,
                                   (pend_q && buf_full_q) ? `STAT_BOTH :
                                   (buf_full_q ? `STAT_BUF_ONLY : `STAT_EMPTY),
                                   1'b0, normal_q, period_q, insert_q};
        `ADR_SAMPLE_LOW:  wb_dat_o <= {24'h000000, low_q};
        `ADR_SAMPLE_HIGH: wb_dat_o <= {24'h000000, high_q};
        `ADR_MODE:    wb_dat_o <= {26'h0, rsel_q, 1'b0, green_q, mute_q, enable_q};
        `ADR_STATUS:  wb_dat_o <= {29'h0, load_q != audio_pwm_pkg::LOAD_IDLE, empty_q, reload_q};
        `ADR_CURRENT: wb_dat_o <= {16'h0000, cur_q};
        default:      wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### src/audio_pwm_params.svh
// Purpose: Constants of the audio PWM sample buffer
// Assumes: Wishbone byte addresses, 32-bit data words
// Notes:   Types live in audio_pwm_pkg
`ifndef AUDIO_PWM_PARAMS_SVH
`define AUDIO_PWM_PARAMS_SVH
`define ADR_CONTROL      6'h00
`define ADR_SAMPLE_LOW   6'h04
`define ADR_SAMPLE_HIGH  6'h08
`define ADR_MODE         6'h0C
`define ADR_STATUS       6'h10
`define ADR_CURRENT      6'h14
`define CTL_CLEAR_BIT    7
`define CTL_NORMAL_BIT   3
`define CTL_PERIOD_BIT   2
`define SAMPLE_DEFAULT   16'h8000
`define LOW_RESET        8'h00
`define HIGH_RESET       8'h80
`define STAT_EMPTY       2'h0
`define STAT_BUF_ONLY    2'h1
`define STAT_BOTH        2'h2
`define PERIOD_MULTI     8'h04
`define PERIOD_LEN       16'h0100
`endif

// ### src/audio_pwm_pkg.sv
// Purpose: Types of the audio PWM sample buffer
// Assumes: Nothing
// Notes:   Constants are macros in audio_pwm_params.svh
package audio_pwm_pkg;
  typedef enum logic [1:0] {
    LOAD_IDLE = 2'b00,
    LOAD_LOW  = 2'b01,
    LOAD_HIGH = 2'b10
  } load_state_t;
endpackage

// ### src/sample_interp.sv
// Purpose: Linear interpolation between two consecutive samples
// Assumes: Step index 0..count, count in {0,1,3,7}
// Notes:   Divisor is a power of two, so division is a shift
`timescale 1ns/1ps
`default_nettype none
module sample_interp #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] prev_i,
  input  wire logic [W-1:0] next_i,
  input  wire logic [1:0]   code_i,
  input  wire logic [2:0]   step_i,
  output logic      [W-1:0] point_o
);
  initial begin
    if (W < 4) $error("W too small");
  end
  logic signed [W+4:0] diff;
  logic signed [W+4:0] acc;
  always_comb begin
    diff = $signed({5'h00, next_i}) - $signed({5'h00, prev_i});
    // Points spaced by difference over count plus one
    acc = (diff * $signed({3'h0, step_i})) >>> code_i;
    point_o = W'($signed({5'h00, prev_i}) + acc);
  end
endmodule
`default_nettype wire

// ### tb/audio_pwm_sample_buffer_props.sv
// Purpose: Port assertions for the audio PWM sample buffer
// Assumes: PERIOD_CLKS of at least 8
// Notes:   Shadows mute and low byte from completed bus writes
`timescale 1ns/1ps
`default_nettype none
module audio_pwm_sample_buffer_props #(
  parameter int PERIOD_CLKS  = 8,
  parameter int MULTI_PERIOD = 2
) (
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o,
  input  wire logic [15:0] sample_o,
  input  wire logic        period_end_o,
  input  wire logic        normal_op_select_o,
  input  wire logic        pwm_enable_o,
  input  wire logic        green_mode_o,
  input  wire logic        reload_done_flag_o,
  input  wire logic        buffer_empty_flag_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire logic  rd = wb_ack_o && !wb_we_i;
  wire logic  wr = wb_ack_o && wb_we_i && wb_sel_i[0];
  logic       mute_q;
  logic [7:0] low_q;
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mute_q <= 1'b0;
    end else if (wr && wb_adr_i == 6'h0C) begin
      mute_q <= wb_dat_i[1];
    end
  end
  // Muting forces the pair back to its default
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || (wr && wb_adr_i == 6'h0C && !wb_dat_i[1])) begin
      low_q <= 8'h00;
    end else if (wr && wb_adr_i == 6'h04 && mute_q) begin
      low_q <= wb_dat_i[7:0];
    end
  end
  property p_status_code;
    rd && wb_adr_i == 6'h00 |-> wb_dat_o[6:5] != 2'b11;
  endproperty
  a_status_code: assert property (p_status_code)
    else $error("buffer status reads 11");
  property p_reload_once;
    reload_done_flag_o |=> !reload_done_flag_o [*6];
  endproperty
  a_reload_once: assert property (p_reload_once)
    else $error("reload flag repeats within a period");
  property p_reload_before_end;
    reload_done_flag_o && pwm_enable_o |=> period_end_o;
  endproperty
  a_reload_before_end: assert property (p_reload_before_end)
    else $error("period end does not follow reload");
  property p_empty_at_read;
    buffer_empty_flag_o |-> reload_done_flag_o;
  endproperty
  a_empty_at_read: assert property (p_empty_at_read)
    else $error("empty flag away from buffer read");
  property p_mute_hold;
    rd && wb_adr_i == 6'h08 && !mute_q |-> wb_dat_o[7:0] == 8'h80;
  endproperty
  a_mute_hold: assert property (p_mute_hold)
    else $error("high byte not default while muted");
  property p_no_one;
    sample_o != 16'h0001;
  endproperty
  a_no_one: assert property (p_no_one)
    else $error("sample 0001 reached the modulator");
  property p_low_rw;
    rd && wb_adr_i == 6'h04 |-> wb_dat_o[7:0] == low_q;
  endproperty
  a_low_rw: assert property (p_low_rw)
    else $error("low byte readback wrong");
  property p_normal_sel;
    wr && wb_adr_i == 6'h00 |=> normal_op_select_o == $past(wb_dat_i[3]);
  endproperty
  a_normal_sel: assert property (p_normal_sel)
    else $error("normal op select not following control");
  property p_enable_mid;
    $rose(pwm_enable_o) |-> ##[0:2] sample_o == 16'h8000;
  endproperty
  a_enable_mid: assert property (p_enable_mid)
    else $error("first sample after enable not midpoint");
  c_reload: cover property (reload_done_flag_o);
  c_empty: cover property (buffer_empty_flag_o);
  c_mute_read: cover property (rd && wb_adr_i == 6'h08 && !mute_q);
endmodule
bind audio_pwm_sample_buffer audio_pwm_sample_buffer_props #(
  .PERIOD_CLKS(PERIOD_CLKS), .MULTI_PERIOD(MULTI_PERIOD)) u_props (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sample_o(sample_o),
  .period_end_o(period_end_o), .normal_op_select_o(normal_op_select_o),
  .pwm_enable_o(pwm_enable_o), .green_mode_o(green_mode_o),
  .reload_done_flag_o(reload_done_flag_o), .buffer_empty_flag_o(buffer_empty_flag_o));
`default_nettype wire

// ### tb/audio_pwm_sample_buffer_tb_top.sv
// Purpose: Self-checking bench for the audio PWM sample buffer
// Assumes: Short period parameters keep the run brief
// Notes:   Row table first, then periods, samples, clear and reset
`timescale 1ns/1ps
`default_nettype none
module audio_pwm_sample_buffer_tb_top;
  typedef struct {logic [5:0] a; logic [7:0] d; logic [7:0] m; logic [7:0] e;} row_t;
  localparam int PER = 8;
  localparam int MUL = 2;
  logic        sys_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        wb_cyc_i  = 1'b0;
  logic        wb_stb_i  = 1'b0;
  logic        wb_we_i   = 1'b0;
  logic [5:0]  wb_adr_i  = 6'h00;
  logic [31:0] wb_dat_i  = 32'h0;
  logic [31:0] wb_dat_o, q;
  logic [15:0] sample_o;
  logic        wb_ack_o, reload_done_flag_o, buffer_empty_flag_o;
  logic        normal_op_select_o, pwm_enable_o, green_mode_o;
  int          error_cnt = 0, checks_done = 0, cyc_cnt = 0, n, i;
  row_t rows [8] = '{'{6'h0C, 8'h01, 8'hFF, 8'h01}, '{6'h04, 8'h34, 8'hFF, 8'h00},
    '{6'h08, 8'h12, 8'hFF, 8'h80}, '{6'h0C, 8'h03, 8'hFF, 8'h03},
    '{6'h04, 8'hA5, 8'hFF, 8'hA5}, '{6'h08, 8'h5A, 8'hFF, 8'h5A},
    '{6'h00, 8'h0B, 8'h1F, 8'h0B}, '{6'h3C, 8'hFF, 8'hFF, 8'h00}};
  audio_pwm_sample_buffer #(.PERIOD_CLKS(PER), .MULTI_PERIOD(MUL)) u_audio_pwm_sample_buffer (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sample_o(sample_o),
    .period_end_o(), .normal_op_select_o(normal_op_select_o),
    .pwm_enable_o(pwm_enable_o), .green_mode_o(green_mode_o),
    .reload_done_flag_o(reload_done_flag_o), .buffer_empty_flag_o(buffer_empty_flag_o));
  task automatic complete_run;
    if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge sys_clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask
  task automatic wait_rel;
    do @(posedge sys_clk_i); while (reload_done_flag_o !== 1'b1);
  endtask
  task automatic play(input logic [15:0] v, input logic [7:0] mode, input logic [15:0] e);
    wb(1'b1, 6'h0C, {24'h0, mode});
    wb(1'b1, 6'h04, {24'h0, v[7:0]});
    wb(1'b1, 6'h08, {24'h0, v[15:8]});
    wait_rel;
    chk("empty_at_write", {31'h0, buffer_empty_flag_o}, 32'h0);
    repeat (3) wait_rel;
    chk("green_mode_o", {31'h0, green_mode_o}, {31'h0, mode[2]});
    chk("sample_o", {16'h0, sample_o}, {16'h0, e});
  endtask
  initial forever #25 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 10000) begin
      error_cnt++;
      complete_run;
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    for (i = 0; i < 8; i++) begin
      wb(1'b1, rows[i].a, {24'h0, rows[i].d});
      wb(1'b0, rows[i].a, 32'h0);
      chk("row", q & {24'h0, rows[i].m}, {24'h0, rows[i].e});
    end
    chk("enable_normal", {30'h0, pwm_enable_o, normal_op_select_o}, 32'h3);
    for (i = 2; i >= 0; i--) begin
      wb(1'b1, 6'h00, (i == 2) ? 32'h4 : (i == 1) ? 32'h2 : 32'h0);
      wait_rel;
      wait_rel;
      n = 0;
      do begin @(posedge sys_clk_i); n++; end while (reload_done_flag_o !== 1'b1);
      chk("period_gap", n, (i == 2) ? PER * MUL : (i == 1) ? PER * 4 : PER);
    end
    play(16'h12FF, 8'h03, 16'h12C0);
    play(16'h12FF, 8'h07, 16'h12E0);
    play(16'h0001, 8'h33, 16'h0000);
    n = 0;
    repeat (4 * PER) begin
      @(posedge sys_clk_i);
      if (buffer_empty_flag_o === 1'b1) n++;
    end
    chk("empty_flag", n != 0, 1);
    wb(1'b1, 6'h00, 32'h07);
    wait_rel;
    wb(1'b1, 6'h04, 32'h11);
    wb(1'b1, 6'h08, 32'h22);
    wb(1'b1, 6'h04, 32'h33);
    wb(1'b1, 6'h08, 32'h44);
    wb(1'b0, 6'h00, 32'h0);
    chk("status_both", q[6:5], 2'b10);
    wb(1'b1, 6'h00, 32'h87);
    wb(1'b0, 6'h00, 32'h0);
    chk("buffer_status", q[6:5], 2'b00);
    sys_rst_i <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    chk("reset_sample", sample_o, 16'h8000);
    wb(1'b0, 6'h08, 32'h0);
    chk("reset_high", q[7:0], 8'h80);
    wb(1'b0, 6'h00, 32'h0);
    chk("reset_control", q[7:0], 8'h00);
    complete_run;
  end
endmodule
`default_nettype wire
